/* File: dv/i2c_host_model.sv */
// Behavioural I2C host: one-byte register writes and reads with a repeated start.
// Assumes SDA has a pull-up; the bench resolves the wire from both pull-down enables.
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Timing reference
  input wire logic linkClk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic hostOe
);
  // Sixteen link clocks a phase keeps the bit rate just under 400 kb/s
  localparam int HALF = 16;
  initial begin
    scl = 1'b1;
    hostOe = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(posedge linkClk);
  endtask
  // Data changes only while SCL is low
  task automatic bit_io(input logic b, output logic got);
    hostOe <= !b;
    half();
    scl <= 1'b1;
    half();
    got = sda;
    scl <= 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, nack);
  endtask
  task automatic start();
    half();
    hostOe <= 1'b1;
    half();
    scl <= 1'b0;
  endtask
  task automatic xfer(input logic rnw, input logic [7:0] ra, input logic [7:0] wd,
      output logic [7:0] rdv, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    rdv = 8'h00;
    start();
    byte_io({DEV_ADDR, 1'b0}, q, n0);
    byte_io(ra, q, n1);
    if (rnw) begin
      hostOe <= 1'b0;
      half();
      scl <= 1'b1;
      start();
      byte_io({DEV_ADDR, 1'b1}, q, n2);
      byte_io(8'hFF, rdv, q[0]);
    end else begin
      byte_io(wd, q, n2);
    end
    hostOe <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    hostOe <= 1'b0;
    half();
    ok = !(n0 || n1 || n2);
  endtask
endmodule // i2c_host_model

/* File: dv/regulator_ctrl_checker.sv */
// Concurrent checks on the ports of the regulator control block.
// Assumes it is bound to the block's top module; every check runs on the core clock.
`timescale 1ns/1ps
module regulator_ctrl_checker
  import regulator_ctrl_pkg::*;
#(
  parameter int unsigned ACCESS_DLY_CYC = 10000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pins
  input wire logic supplyOk,
  input wire logic enPin,
  // Block outputs
  input wire logic [7:0] targetCode,
  input wire logic [20:0] targetUv,
  input wire logic regulatorOn,
  input wire logic softStartBusy,
  input wire logic dischargeOn,
  input wire logic accessReady
);
  logic [19:0] validCnt;
  logic [7:0] gapCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Cycles that supply and enable have both been valid, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      validCnt <= '0;
    else if (!(supplyOk && enPin))
      validCnt <= '0;
    else if (validCnt != 20'hF_FFFF)
      validCnt <= validCnt + 20'h0_0001;
  end
  // Cycles since the target code last moved, saturating
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      gapCnt <= '0;
    else if ($changed(targetCode))
      gapCnt <= '0;
    else if (gapCnt != 8'hFF)
      gapCnt <= gapCnt + 8'h01;
  end
  // Pins pass a short filter, so eight low samples are enough to take effect
  sequence en_low_s;
    !enPin [*8];
  endsequence
  sequence supply_low_s;
    !supplyOk [*8];
  endsequence
  sequence step_s;
    regulatorOn && $past(regulatorOn) && $changed(targetCode);
  endsequence
  uv_formula_a: assert property ($stable(targetCode) |->
    targetUv == 21'(V_BASE_UV + V_STEP_UV * int'(targetCode)))
    else $error("Target microvolts do not follow the target code");
  gate_delay_a: assert property ($rose(accessReady) |-> validCnt >= ACCESS_DLY_CYC)
    else $error("Bus access opened too early");
  gate_closed_a: assert property (en_low_s |-> !accessReady && !regulatorOn)
    else $error("Bus or regulator active with enable low");
  supply_off_a: assert property (supply_low_s |-> !accessReady && !regulatorOn)
    else $error("Bus or regulator active with supply low");
  off_discharge_a: assert property (en_low_s |-> dischargeOn && !softStartBusy)
    else $error("Discharge path off with enable low");
  step_size_a: assert property (step_s |->
    targetCode == $past(targetCode) + 8'h01 || targetCode == $past(targetCode) - 8'h01)
    else $error("Target code moved by more than one step");
  step_gap_a: assert property (step_s |-> gapCnt >= 8'h04)
    else $error("Target code steps closer than five cycles");
  soft_rise_a: assert property (softStartBusy && $past(softStartBusy) && $changed(targetCode)
    |-> targetCode == $past(targetCode) + 8'h01)
    else $error("Soft-start step not upward");
endmodule // regulator_ctrl_checker

/* File: dv/regulator_i2c_voltage_control_tb.sv */
// Bench of the regulator control block: host model on I2C, pins driven from the core clock.
// Assumes the package, the design, the host model and the checker are compiled first.
`timescale 1ns/1ps
module regulator_i2c_voltage_control_tb;
  import regulator_ctrl_pkg::*;
  localparam int unsigned ACC_DLY = 50;
  // Address, reset value, value written, value read back
  localparam logic [31:0] ROWS [7] = '{32'h0050_5252, 32'h0160_3C3C, 32'h0283_8B8B,
    32'h0621_0101, 32'h0700_0101, 32'h0800_0101, 32'h0300_7700};
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst_b, supplyOk, enPin, railSelectPin, scl, hostOe, sdaOe, sdaOut;
  logic regulatorOn, softStartBusy, dischargeOn, forcedPwm, accessReady;
  logic [7:0] targetCode, prevCode;
  logic [20:0] targetUv;
  int num_errors = 0;
  int samples_checked = 0;
  int gapCnt = 0;
  int lastGap = 0;
  wire logic busSda = !sdaOe && !hostOe;
  always #50 core_clk = !core_clk;
  always #40 linkClk = !linkClk;
  regulator_i2c_voltage_control #(.ACCESS_DLY_CYC(ACC_DLY)) i_dut (
    .core_clk(core_clk), .linkClk(linkClk), .rst_b(rst_b), .supplyOk(supplyOk),
    .enPin(enPin), .railSelectPin(railSelectPin), .scl(scl), .sdaIn(busSda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .targetCode(targetCode), .targetUv(targetUv), .regulatorOn(regulatorOn),
    .softStartBusy(softStartBusy), .dischargeOn(dischargeOn), .forcedPwm(forcedPwm),
    .accessReady(accessReady));
  i2c_host_model i_host (.linkClk(linkClk), .sda(busSda), .scl(scl), .hostOe(hostOe));
  // Spacing of the latest target step, in core cycles; falling edge keeps clear of the launch
  always @(negedge core_clk) begin
    prevCode <= targetCode;
    if (targetCode !== prevCode) begin
      lastGap <= gapCnt + 1;
      gapCnt <= 0;
    end else begin
      gapCnt <= gapCnt + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Mode 0: bus gate open, 1: target reaches goal, 2: regulator off
  task automatic wait_on(input int mode, input logic [7:0] goal, output int n);
    n = 0;
    while (!((mode == 0 && accessReady === 1'b1) || (mode == 1 && targetCode === goal)
        || (mode == 2 && regulatorOn === 1'b0))) begin
      @(negedge core_clk);
      n++;
      if (n > 3000) begin
        $display("Timeout in wait mode %0d", mode);
        num_errors++;
        tally_and_finish();
      end
    end
    @(negedge core_clk);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic expOk);
    logic [7:0] q;
    logic ok;
    i_host.xfer(1'b0, a, d, q, ok);
    check(ok, expOk);
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.xfer(1'b1, a, 8'h00, d, ok);
    check(ok, 1'b1);
    check(d, exp);
  endtask
  initial begin
    int n;
    rst_b = 1'b0;
    supplyOk = 1'b0;
    enPin = 1'b0;
    railSelectPin = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(dischargeOn, 1'b1);
    check(regulatorOn, 1'b0);
    check(targetUv, V_BASE_UV);
    check(sdaOut, 1'b0);
    @(posedge core_clk);
    supplyOk <= 1'b1;
    put(ADDR_CODE0, 8'h11, 1'b0);
    $display("Reset and closed bus test done");
    @(posedge core_clk);
    enPin <= 1'b1;
    wait_on(0, 8'h00, n);
    check(n >= ACC_DLY, 1'b1);
    wait_on(1, RST_CODE0, n);
    check(regulatorOn, 1'b1);
    check(lastGap, 32'h0000_000A);
    check(targetUv, V_BASE_UV + V_STEP_UV * 'h50);
    put(ADDR_CODE0, 8'h4E, 1'b1);
    wait_on(1, 8'h4E, n);
    check(lastGap, 32'h0000_0014);
    put(ADDR_CODE0, RST_CODE0, 1'b1);
    wait_on(1, RST_CODE0, n);
    check(lastGap, 32'h0000_0005);
    $display("Start-up and default ramp test done");
    for (int r = 0; r < 7; r++) begin
      get(ROWS[r][31:24], ROWS[r][23:16]);
      put(ROWS[r][31:24], ROWS[r][15:8], 1'b1);
      get(ROWS[r][31:24], ROWS[r][7:0]);
    end
    $display("Register table test done");
    check(forcedPwm, 1'b1);
    @(posedge core_clk);
    railSelectPin <= 1'b1;
    wait_on(1, 8'h3C, n);
    check(targetUv, V_BASE_UV + V_STEP_UV * 60);
    check(lastGap, 32'h0000_0005);
    check(forcedPwm, 1'b0);
    check(targetCode, 8'h3C);
    $display("Rail select test done");
    put(ADDR_CTRL1, 8'h89, 1'b1);
    check(regulatorOn, 1'b1);
    wait_on(2, 8'h00, n);
    check(n > 900 && n <= 1000, 1'b1);
    check(dischargeOn, 1'b1);
    put(ADDR_CTRL1, 8'h0B, 1'b1);
    check(regulatorOn, 1'b0);
    check(dischargeOn, 1'b0);
    $display("Disable delay and discharge test done");
    @(posedge core_clk);
    enPin <= 1'b0;
    repeat (8) @(negedge core_clk);
    check(dischargeOn, 1'b1);
    check(accessReady, 1'b0);
    @(posedge core_clk);
    enPin <= 1'b1;
    wait_on(0, 8'h00, n);
    get(ADDR_CTRL1, RST_CTRL1);
    put(ADDR_CODE1, 8'h44, 1'b1);
    // Supply loss with enable still high: regulator off, bus refused
    @(posedge core_clk);
    supplyOk <= 1'b0;
    repeat (8) @(negedge core_clk);
    check(regulatorOn, 1'b0);
    check(accessReady, 1'b0);
    check(dischargeOn, 1'b1);
    put(ADDR_CODE1, 8'h22, 1'b0);
    @(posedge core_clk);
    supplyOk <= 1'b1;
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(regulatorOn, 1'b0);
    wait_on(0, 8'h00, n);
    get(ADDR_CODE1, RST_CODE1);
    $display("Enable low, supply loss and power-on reset test done");
    tally_and_finish();
  end
endmodule // regulator_i2c_voltage_control_tb
bind regulator_i2c_voltage_control regulator_ctrl_checker #(.ACCESS_DLY_CYC(ACCESS_DLY_CYC))
  i_chk (.core_clk(core_clk), .rst_b(rst_b), .supplyOk(supplyOk), .enPin(enPin),
  .targetCode(targetCode), .targetUv(targetUv), .regulatorOn(regulatorOn),
  .softStartBusy(softStartBusy), .dischargeOn(dischargeOn), .accessReady(accessReady));

/* File: include/regulator_ctrl_pkg.sv */
// Constants, field layout, reset values and state codes of the regulator control block.
// Assumes a 10 MHz core clock and an I2C link sampled on its own free-running link clock.
//
// Notes on behaviour
// - No register read or write is served until 1 ms after supply and enable are valid.
// - Output target is 0.27 V plus code times 6.25 mV, up to 1.395 V.
// - Rail select high uses the code at 0x01, low uses the code at 0x00.
// - Power-on reset returns both voltage codes to their default values.
// - Enable low shuts the regulator down and blocks all bus reads and writes.
// - All registers are held at reset values while enable is low or at power-on reset.
// - After enable rises the output ramps up at the soft-start rate field of 0x06.
// - Enable rising starts the regulator only if the selected rail enable bit is set.
// - Enable delay at 0x07 and disable delay at 0x08 are programmable over the bus.
// - Discharge bit in 0x02 set switches the discharge path on at shutdown.
// - Enable low switches the discharge path on by default.
// - Outside soft start, rising steps use the ramp-up rate, falling steps the ramp-down rate.
// - Reset ramp rates are 12.5 mV/us up and 3.125 mV/us down.
// - The bus target serves fast mode only; the high-speed master code gets no acknowledge.
// - Each rail has a mode bit choosing forced PWM or automatic power saving.
package regulator_ctrl_pkg;
  localparam logic [7:0] ADDR_CODE0 = 8'h00;
  localparam logic [7:0] ADDR_CODE1 = 8'h01;
  localparam logic [7:0] ADDR_CTRL1 = 8'h02;
  localparam logic [7:0] ADDR_CTRL2 = 8'h06;
  localparam logic [7:0] ADDR_ENDLY = 8'h07;
  localparam logic [7:0] ADDR_DISDLY = 8'h08;
  localparam int DISCHARGE_BIT_BIT = 7;
  localparam int UP_LSB = 5;
  localparam int MODE1_BIT = 4;
  localparam int MODE0_BIT = 3;
  localparam int EN1_BIT = 1;
  localparam int EN0_BIT = 0;
  localparam int DN_LSB = 4;
  localparam int SS_LSB = 0;
  localparam logic [7:0] RST_CODE0 = 8'h50;
  localparam logic [7:0] RST_CODE1 = 8'h60;
  localparam logic [7:0] RST_CTRL1 = 8'h83;
  localparam logic [7:0] RST_CTRL2 = 8'h21;
  localparam logic [7:0] RST_DLY = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hB4;
  localparam int V_BASE_UV = 270000;
  localparam int V_STEP_UV = 6250;
  localparam int CORE_CLK_MHZ = 10;
  localparam int STEP_TIME_NS = 500;
  localparam int STEP_BASE_CYC = (STEP_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int ACCESS_DLY_US = 1000;
  localparam int DLY_UNIT_US = 100;
  localparam int DLY_UNIT_CYC = DLY_UNIT_US * CORE_CLK_MHZ;
  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_ENDLY = 3'b001,
    SEQ_SOFT = 3'b010,
    SEQ_ON = 3'b011,
    SEQ_DISDLY = 3'b100
  } seq_st_t;
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_AACK = 3'b010,
    L_REG = 3'b011,
    L_WDAT = 3'b100,
    L_DACK = 3'b101,
    L_RDAT = 3'b110,
    L_RACK = 3'b111
  } link_st_t;
endpackage

/* File: rtl/i2c_target_link.sv */
// I2C target on the link clock: oversamples the bus, serves register reads and writes.
// Assumes the link clock runs free at several times the bus bit rate.
`timescale 1ns/1ps
module i2c_target_link #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clock and reset
  input wire logic linkClk,
  input wire logic rst_b,
  // Bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Core side
  input wire logic accessOk,
  input wire logic [7:0] rdData,
  input wire logic rdAckTog,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData,
  output logic wrTog,
  output logic [7:0] rdAddr,
  output logic rdReqTog
);
  import regulator_ctrl_pkg::*;
  logic [2:0] s1_r, s2_r, s3_r, q_r, p_r;
  link_st_t st_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, tx_r, ptr_r, rxByte;
  logic isRead_r, ackOn_r, nack_r;
  logic sclRise, sclFall, startC, stopC;

  // Open drain: the pin is only ever pulled low
  assign sdaOut = 1'b0;

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 3'b011;
      s2_r <= 3'b011;
      s3_r <= 3'b011;
      q_r <= 3'b011;
      p_r <= 3'b011;
    end else begin
      s1_r <= {accessOk, sdaIn, scl};
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s2_r & s3_r) | (q_r & (s2_r ^ s3_r));
      p_r <= q_r;
    end
  end

  assign sclRise = q_r[0] & ~p_r[0];
  assign sclFall = ~q_r[0] & p_r[0];
  assign startC = q_r[0] & p_r[0] & p_r[1] & ~q_r[1];
  assign stopC = q_r[0] & p_r[0] & ~p_r[1] & q_r[1];
  assign rxByte = {shift_r[6:0], q_r[1]};

  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= L_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      isRead_r <= 1'b0;
      ackOn_r <= 1'b0;
      nack_r <= 1'b1;
      sdaOe <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 8'h00;
      wrTog <= 1'b0;
      rdAddr <= 8'h00;
      rdReqTog <= 1'b0;
    end else if (startC) begin
      st_r <= L_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopC) begin
      st_r <= L_IDLE;
      sdaOe <= 1'b0;
    end else begin
      if (sclRise && (st_r == L_ADDR || st_r == L_REG || st_r == L_WDAT || st_r == L_RDAT)) begin
        shift_r <= rxByte;
        bitCnt_r <= bitCnt_r + 4'h1;
      end
      ackOn_r <= ackOn_r & ~sclFall;
      unique case (st_r)
        L_IDLE: ;
        L_ADDR: begin
          // Master codes and access before the gate opens get no acknowledge
          if (sclRise && bitCnt_r == 4'h7) begin
            st_r <= (rxByte[7:1] == DEV_ADDR && q_r[2]) ? L_AACK : L_IDLE;
            isRead_r <= rxByte[0];
          end
        end
        L_AACK, L_DACK: begin
          if (sclFall && !ackOn_r) begin
            sdaOe <= 1'b1;
            ackOn_r <= 1'b1;
          end else if (sclFall) begin
            bitCnt_r <= 4'h0;
            sdaOe <= 1'b0;
            st_r <= (st_r == L_AACK) ? L_REG : L_WDAT;
            if (st_r == L_AACK && isRead_r) begin
              st_r <= L_RDAT;
              tx_r <= rdData;
              sdaOe <= ~rdData[7];
            end
          end
        end
        L_REG, L_WDAT: begin
          if (sclRise && bitCnt_r == 4'h7) begin
            st_r <= L_DACK;
            ptr_r <= (st_r == L_REG) ? rxByte : ptr_r + 8'h01;
            rdAddr <= (st_r == L_REG) ? rxByte : ptr_r + 8'h01;
            rdReqTog <= ~rdReqTog;
            if (st_r == L_WDAT) begin
              wrAddr <= ptr_r;
              wrData <= rxByte;
              wrTog <= ~wrTog;
            end
          end
        end
        L_RDAT: begin
          if (sclFall && bitCnt_r != 4'h0) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sdaOe <= ~tx_r[6];
          end
          if (sclRise && bitCnt_r == 4'h7) begin
            st_r <= L_RACK;
            ptr_r <= ptr_r + 8'h01;
            rdAddr <= ptr_r + 8'h01;
            rdReqTog <= ~rdReqTog;
          end
        end
        L_RACK: begin
          if (sclRise) begin
            nack_r <= q_r[1];
            ackOn_r <= 1'b1;
          end else if (sclFall && !ackOn_r) begin
            sdaOe <= 1'b0;
          end else if (sclFall) begin
            bitCnt_r <= 4'h0;
            st_r <= nack_r ? L_IDLE : L_RDAT;
            tx_r <= rdData;
            sdaOe <= ~nack_r & ~rdData[7];
          end
        end
      endcase
    end
  end
endmodule // i2c_target_link

/* File: rtl/regulator_i2c_voltage_control.sv */
// Control logic of a step-down regulator: register bank, rail select, start and ramp sequencing.
// Assumes the analog stage follows targetCode and the outputs below; the bus pins are external.
`timescale 1ns/1ps
module regulator_i2c_voltage_control #(
  parameter int unsigned ACCESS_DLY_CYC =
    regulator_ctrl_pkg::ACCESS_DLY_US * regulator_ctrl_pkg::CORE_CLK_MHZ,
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic linkClk,
  input wire logic rst_b,
  // Supply, enable and rail select pins
  input wire logic supplyOk,
  input wire logic enPin,
  input wire logic railSelectPin,
  // I2C pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Power stage controls
  output logic [7:0] targetCode,
  output logic [20:0] targetUv,
  output logic regulatorOn,
  output logic softStartBusy,
  output logic dischargeOn,
  output logic forcedPwm,
  output logic accessReady
);
  import regulator_ctrl_pkg::*;

  if (ACCESS_DLY_CYC < 1 || ACCESS_DLY_CYC > 1048575) begin : g_bad_access_dly
    $error("ACCESS_DLY_CYC must lie between 1 and 1048575");
  end

  logic [7:0] wrAddr, wrData, rdAddr;
  logic wrTog, rdReqTog;
  logic [4:0] pinRaw, pinQ;
  logic supQ, enQ, selQ;

  // Pins and the two link toggles share one filter: three flops, change once 2nd and 3rd agree
  assign pinRaw = {rdReqTog, wrTog, railSelectPin, enPin, supplyOk};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    logic s1_r, s2_r, s3_r, q_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        q_r <= 1'b0;
      end else begin
        s1_r <= pinRaw[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          q_r <= s3_r;
        end
      end
    end
    assign pinQ[i] = q_r;
  end

  assign supQ = pinQ[0];
  assign enQ = pinQ[1];
  assign selQ = pinQ[2];

  // Access gate
  logic [19:0] gateCnt_r;
  logic accessOk_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gateCnt_r <= 20'h0_0000;
      accessOk_r <= 1'b0;
    end else if (!(supQ && enQ)) begin
      gateCnt_r <= 20'h0_0000;
      accessOk_r <= 1'b0;
    end else if (gateCnt_r == 20'(ACCESS_DLY_CYC)) begin
      accessOk_r <= 1'b1;
    end else begin
      gateCnt_r <= gateCnt_r + 20'h0_0001;
    end
  end

  assign accessReady = accessOk_r;

  // Link toggle events
  logic wrSeen_r, rdSeen_r, wrEvt, rdEvt;

  assign wrEvt = pinQ[3] != wrSeen_r;
  assign rdEvt = pinQ[4] != rdSeen_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrSeen_r <= 1'b0;
      rdSeen_r <= 1'b0;
    end else begin
      wrSeen_r <= pinQ[3];
      rdSeen_r <= pinQ[4];
    end
  end

  // Register bank
  logic [7:0] code0_r, code1_r, ctrl1_r, ctrl2_r, enDly_r, disDly_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      code0_r <= RST_CODE0;
      code1_r <= RST_CODE1;
      ctrl1_r <= RST_CTRL1;
      ctrl2_r <= RST_CTRL2;
      enDly_r <= RST_DLY;
      disDly_r <= RST_DLY;
    end else if (!enQ) begin
      code0_r <= RST_CODE0;
      code1_r <= RST_CODE1;
      ctrl1_r <= RST_CTRL1;
      ctrl2_r <= RST_CTRL2;
      enDly_r <= RST_DLY;
      disDly_r <= RST_DLY;
    end else if (wrEvt && accessOk_r) begin
      unique case (wrAddr)
        ADDR_CODE0: code0_r <= wrData;
        ADDR_CODE1: code1_r <= wrData;
        ADDR_CTRL1: ctrl1_r <= wrData;
        ADDR_CTRL2: ctrl2_r <= wrData;
        ADDR_ENDLY: enDly_r <= wrData;
        ADDR_DISDLY: disDly_r <= wrData;
        default: ;
      endcase
    end
  end

  // Read path: the link prefetches, the core answers with data and an acknowledge toggle
  logic [7:0] rdMux, rdData_r;
  logic rdAckTog_r;

  always_comb begin
    unique case (rdAddr)
      ADDR_CODE0: rdMux = code0_r;
      ADDR_CODE1: rdMux = code1_r;
      ADDR_CTRL1: rdMux = ctrl1_r;
      ADDR_CTRL2: rdMux = ctrl2_r;
      ADDR_ENDLY: rdMux = enDly_r;
      ADDR_DISDLY: rdMux = disDly_r;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 8'h00;
      rdAckTog_r <= 1'b0;
    end else if (rdEvt) begin
      rdData_r <= rdMux;
      rdAckTog_r <= pinQ[4];
    end
  end

  // Rail selection
  logic selEnBit;
  logic [7:0] selCodeRaw, selCode;

  assign selEnBit = selQ ? ctrl1_r[EN1_BIT] : ctrl1_r[EN0_BIT];
  assign selCodeRaw = selQ ? code1_r : code0_r;
  // Codes above the top of the range are held at the top
  assign selCode = (selCodeRaw > CODE_MAX) ? CODE_MAX : selCodeRaw;

  // Start and stop sequencing
  seq_st_t st_r;
  logic enPrev_r, enRise;
  logic [15:0] dlyCnt_r;
  logic [7:0] target_r;

  assign enRise = enQ & ~enPrev_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enPrev_r <= 1'b0;
    end else begin
      enPrev_r <= enQ;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= SEQ_OFF;
    end else if (!enQ || !supQ) begin
      st_r <= SEQ_OFF;
    end else begin
      unique case (st_r)
        SEQ_OFF: begin
          if (enRise && selEnBit) begin
            st_r <= SEQ_ENDLY;
          end
        end
        SEQ_ENDLY: begin
          if (dlyCnt_r == 16'h0000) begin
            st_r <= SEQ_SOFT;
          end
        end
        SEQ_SOFT: begin
          if (target_r == selCode) begin
            st_r <= SEQ_ON;
          end
        end
        SEQ_ON: begin
          if (!selEnBit) begin
            st_r <= SEQ_DISDLY;
          end
        end
        SEQ_DISDLY: begin
          if (dlyCnt_r == 16'h0000) begin
            st_r <= SEQ_OFF;
          end
        end
        default: st_r <= SEQ_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dlyCnt_r <= 16'h0000;
    end else if (st_r == SEQ_OFF && enRise && selEnBit) begin
      dlyCnt_r <= 16'(int'(enDly_r[3:0]) * DLY_UNIT_CYC);
    end else if (st_r == SEQ_ON && !selEnBit) begin
      dlyCnt_r <= 16'(int'(disDly_r[3:0]) * DLY_UNIT_CYC);
    end else if (dlyCnt_r != 16'h0000) begin
      dlyCnt_r <= dlyCnt_r - 16'h0001;
    end
  end

  // Ramp engine: one code step per period, period doubles per rate code
  logic [1:0] rateCode;
  logic [5:0] period, stepCnt_r;
  logic stepDue, goingUp;

  assign goingUp = target_r < selCode;

  always_comb begin
    if (st_r == SEQ_SOFT) begin
      rateCode = ctrl2_r[SS_LSB +: 2];
    end else if (goingUp) begin
      rateCode = ctrl1_r[UP_LSB +: 2];
    end else begin
      rateCode = ctrl2_r[DN_LSB +: 2];
    end
  end

  assign period = 6'(STEP_BASE_CYC << rateCode);
  assign stepDue = stepCnt_r >= period - 6'h01;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_r <= 8'h00;
      stepCnt_r <= 6'h00;
    end else if (st_r == SEQ_OFF || st_r == SEQ_ENDLY) begin
      target_r <= 8'h00;
      stepCnt_r <= 6'h00;
    end else if (st_r == SEQ_DISDLY || target_r == selCode) begin
      stepCnt_r <= 6'h00;
    end else if (stepDue) begin
      stepCnt_r <= 6'h00;
      target_r <= goingUp ? target_r + 8'h01 : target_r - 8'h01;
    end else begin
      stepCnt_r <= stepCnt_r + 6'h01;
    end
  end

  // Registered outputs to the power stage
  logic on;

  assign on = st_r == SEQ_SOFT || st_r == SEQ_ON || st_r == SEQ_DISDLY;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regulatorOn <= 1'b0;
      softStartBusy <= 1'b0;
      dischargeOn <= 1'b1;
      forcedPwm <= 1'b0;
      targetCode <= 8'h00;
      targetUv <= 21'(V_BASE_UV);
    end else begin
      regulatorOn <= on;
      softStartBusy <= st_r == SEQ_SOFT;
      // Enable low resets the discharge bit to one, so the path defaults on
      dischargeOn <= !on && ctrl1_r[DISCHARGE_BIT_BIT];
      forcedPwm <= selQ ? ctrl1_r[MODE1_BIT] : ctrl1_r[MODE0_BIT];
      targetCode <= target_r;
      targetUv <= 21'(V_BASE_UV + int'(target_r) * V_STEP_UV);
    end
  end

  i2c_target_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .linkClk(linkClk),
    .rst_b(rst_b),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .accessOk(accessOk_r),
    .rdData(rdData_r),
    .rdAckTog(rdAckTog_r),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrTog(wrTog),
    .rdAddr(rdAddr),
    .rdReqTog(rdReqTog)
  );
endmodule // regulator_i2c_voltage_control
